// ===== hdl/config_state_readback.sv
`timescale 1ns/10ps
`include "readback_params.svh"

module config_state_readback
	import readback_pkg::*;
#(
	parameter int NUM_FRAMES = `RB_NUM_FRAMES,
	parameter int FRAME_BITS = `RB_FRAME_BITS,
	parameter int NUM_CELLS  = `RB_NUM_CELLS,
	parameter int NUM_IO     = `RB_NUM_IO,
	parameter int FIFO_DEPTH = `RB_FIFO_DEPTH
) (
	// System clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// Shift clock from the outside party
	input  wire logic                          rb_clk_i,
	// Configuration frame load
	input  wire logic [FRAME_BITS+`RB_CHECK_BITS-1:0] cfg_word_i,
	input  wire logic                          cfg_valid_i,
	output logic                               cfg_ready_o,
	output logic                               config_done_o,
	output logic                               config_status_o,
	// Logic cells used as RAM
	input  wire logic                          ram_we_i,
	input  wire logic [$clog2(NUM_FRAMES)-1:0] ram_frame_i,
	input  wire logic [$clog2(FRAME_BITS)-1:0] ram_bit_i,
	input  wire logic                          ram_wdata_i,
	// Observed logic cell nodes
	input  wire logic [NUM_CELLS-1:0]          cell_fg_x_i,
	input  wire logic [NUM_CELLS-1:0]          cell_fg_y_i,
	input  wire logic [NUM_CELLS-1:0]          cell_ff_out_a_i,
	input  wire logic [NUM_CELLS-1:0]          cell_ff_out_b_i,
	// Observed io cell nodes
	input  wire logic [NUM_IO-1:0]             io_out_ff_i,
	input  wire logic [NUM_IO-1:0]             io_in_path_a_i,
	input  wire logic [NUM_IO-1:0]             io_in_path_b_i,
	// Option pin: include live state in the stream
	input  wire logic                          user_capture_en_i,
	// Readback link, on the shift clock
	input  wire logic                          capture_request_i,
	input  wire logic                          tap_readback_i,
	output logic                               capture_active_o,
	output logic                               rb_data_o
);
	localparam int FW        = FRAME_BITS + `RB_CHECK_BITS;
	localparam int USER_BITS = 4 * NUM_CELLS + 3 * NUM_IO;
	localparam int FRM_LEN   = 1 + FRAME_BITS + `RB_STOP_BITS;
	localparam int LEN       = (NUM_FRAMES + 1) * FRM_LEN + `RB_CRC_BITS;
	localparam int CW        = $clog2(LEN + 1);
	localparam int FCW       = $clog2(NUM_FRAMES);

	// The user frame must hold every observed node
	if (FRAME_BITS < USER_BITS || FRAME_BITS < `RB_CHECK_BITS || NUM_FRAMES < 2)
	begin : g_size_check
		$error("config_state_readback: frame too narrow or too few frames");
	end

	// Four check bits: bit k is parity of data bits at k, k+4, k+8 ...
	function automatic logic [`RB_CHECK_BITS-1:0] frame_check(
		input logic [FRAME_BITS-1:0] data
	);
		logic [`RB_CHECK_BITS-1:0] c;
		c = '0;
		for (int i = 0; i < FRAME_BITS; i++) begin
			c[i % `RB_CHECK_BITS] = c[i % `RB_CHECK_BITS] ^ data[i];
		end
		return c;
	endfunction : frame_check

	// Whole stream, first bit out in the top position
	function automatic logic [LEN-1:0] build_stream(
		input logic [NUM_FRAMES*FRAME_BITS-1:0] cfg,
		input logic [FRAME_BITS-1:0]            usr
	);
		logic [LEN-1:0]        s;
		logic [FRAME_BITS-1:0] fw;
		logic [15:0]           crc;
		logic                  fb;
		int                    p;
		s   = '1;
		crc = `RB_CRC_INIT;
		p   = LEN - 1;
		for (int f = 0; f <= NUM_FRAMES; f++) begin
			if (f < NUM_FRAMES) begin
				fw = cfg[f*FRAME_BITS +: FRAME_BITS];
			end else begin
				fw = usr;
			end
			s[p] = `RB_START_BIT;
			p    = p - 1;
			for (int b = FRAME_BITS - 1; b >= 0; b--) begin
				s[p] = fw[b];
				p    = p - 1;
			end
			// Stop bits stay at one from the fill above
			p = p - `RB_STOP_BITS;
		end
		for (int i = LEN - 1; i >= `RB_CRC_BITS; i--) begin
			fb  = crc[15] ^ s[i];
			crc = {crc[14:0], 1'b0} ^ (fb ? `RB_CRC_POLY : 16'h0000);
		end
		s[`RB_CRC_BITS-1:0] = crc[`RB_CRC_BITS-1:0];
		return s;
	endfunction : build_stream

	// ---------------- System clock domain ----------------

	logic [FRAME_BITS-1:0]            cfg_mem [NUM_FRAMES];  // Configuration memory
	logic [NUM_FRAMES*FRAME_BITS-1:0] cfg_flat;              // Memory as one vector
	logic [USER_BITS-1:0]             user_nodes;            // Live node values
	logic [FRAME_BITS-1:0]            user_frame;            // User frame as streamed
	logic [LEN-1:0]                   snap;                  // Holding register
	load_state_e                      ld_state;              // Loader state
	logic [FCW-1:0]                   ld_frame;              // Next frame to load
	logic [FW-1:0]                    fifo_data;             // Frame word at FIFO head
	logic                             fifo_valid;            // Head word present
	logic                             fifo_ready;            // Loader takes the head
	logic                             ld_ok;                 // Head word passes check
	logic [2:0]                       cap_en_s;              // Option pin synchroniser
	logic                             cap_en;                // Filtered option level
	logic [2:0]                       req_s;                 // Request toggle synchroniser
	logic                             req_seen;              // Last request toggle served
	logic                             ack_tog;               // Capture done toggle
	logic                             req_tog;               // Request toggle, shift side

	// Frame words are buffered so a burst can arrive while RAM writes hold the port
	word_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH)
	) i_word_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_data_i   (cfg_word_i),
		.in_valid_i  (cfg_valid_i),
		.in_ready_o  (cfg_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_ready)
	);

	// RAM writes own the memory port, so loading stalls under them
	assign fifo_ready = (ld_state == LD_RUN) && !ram_we_i;
	assign ld_ok      = frame_check(fifo_data[FW-1:`RB_CHECK_BITS])
	                    == fifo_data[`RB_CHECK_BITS-1:0];

	// Loader: check each frame, stop for good on a bad one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ld_state <= LD_RUN;
			ld_frame <= '0;
		end else begin
			case (ld_state)
				LD_RUN: begin
					if (fifo_valid && fifo_ready) begin
						if (!ld_ok) begin
							ld_state <= LD_ERR;
						end else if (ld_frame == FCW'(NUM_FRAMES - 1)) begin
							ld_state <= LD_DONE;
						end else begin
							ld_frame <= ld_frame + FCW'(1);
						end
					end
				end
				LD_DONE: ld_state <= LD_DONE;
				LD_ERR:  ld_state <= LD_ERR;
				default: ld_state <= LD_ERR;
			endcase
		end
	end

	// Status outputs follow the loader state directly from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			config_done_o   <= 1'b0;
			config_status_o <= 1'b1;
		end else begin
			config_done_o   <= (ld_state == LD_DONE);
			config_status_o <= (ld_state != LD_ERR);
		end
	end

	// Memory port: RAM writes land in configuration bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int f = 0; f < NUM_FRAMES; f++) begin
				cfg_mem[f] <= '0;
			end
		end else if (ram_we_i) begin
			cfg_mem[ram_frame_i][ram_bit_i] <= ram_wdata_i;
		end else if (fifo_valid && fifo_ready && ld_ok) begin
			cfg_mem[ld_frame] <= fifo_data[FW-1:`RB_CHECK_BITS];
		end
	end

	// Flatten memory and gather the observed nodes per cell
	for (genvar g = 0; g < NUM_FRAMES; g++) begin : g_flat
		assign cfg_flat[g*FRAME_BITS +: FRAME_BITS] = cfg_mem[g];
	end
	for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
		assign user_nodes[4*c +: 4] = {cell_fg_x_i[c], cell_fg_y_i[c],
		                               cell_ff_out_a_i[c], cell_ff_out_b_i[c]};
	end
	for (genvar k = 0; k < NUM_IO; k++) begin : g_io
		assign user_nodes[4*NUM_CELLS + 3*k +: 3] = {io_out_ff_i[k],
		                                             io_in_path_a_i[k],
		                                             io_in_path_b_i[k]};
	end

	// Live state goes out inverted; with the option off it reads as ones
	always_comb begin
		user_frame = '1;
		if (cap_en) begin
			user_frame[USER_BITS-1:0] = ~user_nodes;
		end
	end

	// Option pin crosses in on three flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_en_s <= '0;
			cap_en   <= 1'b0;
		end else begin
			cap_en_s <= {cap_en_s[1:0], user_capture_en_i};
			if (cap_en_s[1] == cap_en_s[2]) begin
				cap_en <= cap_en_s[2];
			end
		end
	end

	// Capture: one step into the holding register, nothing else is touched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_s    <= '0;
			req_seen <= 1'b0;
			ack_tog  <= 1'b0;
			snap     <= '1;
		end else begin
			req_s <= {req_s[1:0], req_tog};
			if (req_s[1] == req_s[2] && req_s[2] != req_seen) begin
				req_seen <= req_s[2];
				snap     <= build_stream(cfg_flat, user_frame);
				ack_tog  <= ~ack_tog;
			end
		end
	end

	// ---------------- Shift clock domain ----------------

	logic [1:0]     rb_rst_s;   // Reset carried onto the shift clock
	logic           rb_rst;     // Reset on the shift clock
	logic [2:0]     done_s;     // Configured level synchroniser
	logic           done_rb;    // Configured, seen on the shift clock
	logic [2:0]     ack_s;      // Capture done synchroniser
	logic           ack_seen;   // Last capture toggle consumed
	logic           trig_prev;  // Request level one edge ago
	logic           trig;       // Rising request this edge
	logic           ack_evt;    // Snapshot is ready to load
	shift_state_e   rb_state;   // Engine state
	logic [LEN-1:0] shreg;      // Shift register
	logic [CW-1:0]  rb_cnt;     // Bits shifted out so far

	// The shift clock may stop between readbacks, so reset needs it running
	always_ff @(posedge rb_clk_i) begin
		rb_rst_s <= {rb_rst_s[0], rst_i};
	end
	assign rb_rst = rb_rst_s[1];

	// Request pins come from logic on this clock; tap start joins them
	assign trig = (capture_request_i || tap_readback_i) && !trig_prev;
	assign ack_evt = (ack_s[1] == ack_s[2]) && (ack_s[2] != ack_seen);

	// Crossings into the shift domain
	always_ff @(posedge rb_clk_i) begin
		if (rb_rst) begin
			done_s    <= '0;
			done_rb   <= 1'b0;
			ack_s     <= '0;
			trig_prev <= 1'b1;
		end else begin
			done_s    <= {done_s[1:0], config_done_o};
			ack_s     <= {ack_s[1:0], ack_tog};
			trig_prev <= capture_request_i || tap_readback_i;
			if (done_s[1] == done_s[2]) begin
				done_rb <= done_s[2];
			end
		end
	end

	// Engine: request, wait for the snapshot, shift it out
	always_ff @(posedge rb_clk_i) begin
		if (rb_rst) begin
			rb_state         <= RB_IDLE;
			req_tog          <= 1'b0;
			ack_seen         <= 1'b0;
			shreg            <= '1;
			rb_cnt           <= '0;
			capture_active_o <= `RB_ACTIVE_IDLE;
			rb_data_o        <= `RB_DATA_IDLE;
		end else begin
			case (rb_state)
				RB_IDLE: begin
					rb_data_o <= `RB_DATA_IDLE;
					// Only a configured device answers; no test mode needed
					if (trig && done_rb) begin
						req_tog          <= ~req_tog;
						capture_active_o <= 1'b1;
						rb_state         <= RB_WAIT;
					end
				end
				RB_WAIT: begin
					// Leading ones while the snapshot crosses over
					rb_data_o <= `RB_DATA_IDLE;
					if (ack_evt) begin
						ack_seen <= ack_s[2];
						shreg    <= snap;
						rb_cnt   <= '0;
						rb_state <= RB_SHIFT;
					end
				end
				RB_SHIFT: begin
					// New requests fall through here untouched
					rb_data_o <= shreg[LEN-1];
					shreg     <= {shreg[LEN-2:0], 1'b1};
					rb_cnt    <= rb_cnt + CW'(1);
					if (rb_cnt == CW'(LEN - 1)) begin
						capture_active_o <= 1'b0;
						rb_state         <= RB_IDLE;
					end
				end
				default: rb_state <= RB_IDLE;
			endcase
		end
	end

endmodule : config_state_readback

// ===== hdl/word_fifo.sv
`timescale 1ns/10ps
`include "readback_params.svh"

module word_fifo
	import readback_pkg::*;
#(
	parameter int WIDTH = 20,
	parameter int DEPTH = `RB_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Filling side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	// Draining side
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	// Pointers wrap naturally, so the depth must be a power of two
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
		$error("word_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];  // Storage array
	logic [AW-1:0]    wr_ptr;       // Next slot to write
	logic [AW-1:0]    rd_ptr;       // Next slot to read
	logic [AW:0]      count;        // Words held in the array
	logic             do_wr;        // Word accepted this cycle
	logic             do_rd;        // Word moved to the output register

	// Full is honest: no write while every slot holds a word
	assign in_ready_o = (count < (AW+1)'(DEPTH));
	assign do_wr      = in_valid_i && in_ready_o;
	assign do_rd      = (count != '0) && (!out_valid_o || out_ready_i);

	// Array writes
	always_ff @(posedge clk_i) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

	// Registered read port keeps data off a combinational path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end else if (do_rd) begin
			out_valid_o <= 1'b1;
			out_data_o  <= mem[rd_ptr];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end

endmodule : word_fifo

// ===== pkg/readback_params.svh
`ifndef READBACK_PARAMS_SVH
`define READBACK_PARAMS_SVH

// Frame layout of both the load stream and the readback stream
`define RB_START_BIT      1'b0
`define RB_STOP_BITS      4
`define RB_CHECK_BITS     4
`define RB_CRC_BITS       11

// Signature generator over the readback stream
`define RB_CRC_POLY       16'h8005
`define RB_CRC_INIT       16'h0000

// Reset values of the serial link
`define RB_DATA_IDLE      1'b1
`define RB_ACTIVE_IDLE    1'b0

// Documented defaults of the array size
`define RB_NUM_FRAMES     4
`define RB_FRAME_BITS     16
`define RB_NUM_CELLS      2
`define RB_NUM_IO         2
`define RB_FIFO_DEPTH     16

// Shift clock limits the outside party keeps to
`define RB_SHIFT_FMIN_HZ  10000
`define RB_SHIFT_FMAX_HZ  1000000

`endif

// ===== pkg/readback_pkg.sv
package readback_pkg;

	// Configuration loader, Gray along run to done
	typedef enum logic [1:0] {
		LD_RUN  = 2'b00,
		LD_DONE = 2'b01,
		LD_ERR  = 2'b11
	} load_state_e;

	// Readback engine on the shift clock, Gray along idle, wait, shift
	typedef enum logic [1:0] {
		RB_IDLE  = 2'b00,
		RB_WAIT  = 2'b01,
		RB_SHIFT = 2'b11
	} shift_state_e;

endpackage : readback_pkg

// ===== tb/config_state_readback_sva.sv
`timescale 1ns/10ps
// Watches the load status and the readback link at the top ports
module config_state_readback_sva #(
	parameter int NUM_FRAMES = 4,
	parameter int FRAME_BITS = 16
) (
	// Clocks and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rb_clk_i,
	// Load status
	input wire logic config_done_o,
	input wire logic config_status_o,
	// Readback link
	input wire logic capture_request_i,
	input wire logic tap_readback_i,
	input wire logic capture_active_o,
	input wire logic rb_data_o
);
	localparam int LEN = (NUM_FRAMES + 1) * (FRAME_BITS + 5) + 11;
	logic [9:0] act_cnt; // Shift cycles spent in the current readback

	// Counted in the shift domain, because the stream length is only visible there
	always_ff @(posedge rb_clk_i) begin
		if (rst_i || !capture_active_o) begin
			act_cnt <= 10'h000;
		end else begin
			act_cnt <= act_cnt + 10'h001;
		end
	end

	chk_reset_values: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> config_status_o && !config_done_o) else $error("status not reset");
	chk_status_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		!config_status_o |=> !config_status_o && !config_done_o) else $error("error lost");
	chk_done_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		config_done_o |=> config_done_o && config_status_o) else $error("done lost");
	chk_no_disturb: assert property (@(posedge clk_i) disable iff (rst_i)
		capture_active_o |=> $stable(config_done_o) && $stable(config_status_o))
		else $error("status moved in readback");
	chk_start_done: assert property (@(posedge rb_clk_i) disable iff (rst_i)
		$rose(capture_active_o) |-> config_done_o) else $error("readback before load");
	chk_start_edge: assert property (@(posedge rb_clk_i) disable iff (rst_i)
		$rose(capture_active_o) |-> ($past(capture_request_i) || $past(tap_readback_i))
		&& !$past(capture_request_i, 2) && !$past(tap_readback_i, 2))
		else $error("start without request edge");
	chk_idle_high: assert property (@(posedge rb_clk_i) disable iff (rst_i)
		!capture_active_o && !$past(capture_active_o) |-> rb_data_o) else $error("idle data low");
	chk_stream_len: assert property (@(posedge rb_clk_i) disable iff (rst_i)
		$fell(capture_active_o) |-> act_cnt >= LEN) else $error("stream too short");
	chk_active_bound: assert property (@(posedge rb_clk_i) disable iff (rst_i)
		capture_active_o |-> act_cnt < LEN + 24) else $error("readback overruns");
endmodule : config_state_readback_sva

bind config_state_readback config_state_readback_sva #(
	.NUM_FRAMES(NUM_FRAMES),
	.FRAME_BITS(FRAME_BITS)
) i_config_state_readback_sva (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.rb_clk_i(rb_clk_i),
	.config_done_o(config_done_o),
	.config_status_o(config_status_o),
	.capture_request_i(capture_request_i),
	.tap_readback_i(tap_readback_i),
	.capture_active_o(capture_active_o),
	.rb_data_o(rb_data_o)
);

// ===== tb/readback_host.sv
`timescale 1ns/10ps
// Outside controller: makes the shift clock, requests one device, gathers its stream
module readback_host #(
	parameter int LEN = 74
) (
	output logic      rb_clk_o,
	output logic      capture_request_o,
	output logic      tap_readback_o,
	input wire logic  capture_active_i,
	input wire logic  rb_data_i
);
	bit run = 1'b0; // Clock stands still low unless a transfer needs it
	initial rb_clk_o = 1'b0;
	initial capture_request_o = 1'b0;
	initial tap_readback_o = 1'b0;

	// 125 ns shift clock keeps runs short; field use stays within 10 kHz..1 MHz
	always begin
		#62.5;
		if (run || rb_clk_o) begin
			rb_clk_o = ~rb_clk_o;
		end
	end

	// Run the clock for a number of rising edges
	task automatic spin(input int n);
		run = 1'b1;
		repeat (n) @(posedge rb_clk_o);
		run = 1'b0;
	endtask : spin

	// One readback; poke raises the request again in mid-shift
	task automatic read(input bit tap, input bit poke, output logic [LEN-1:0] s);
		logic q[$];
		int   n;
		spin(8);
		run = 1'b1;
		if (tap) begin
			tap_readback_o <= 1'b1;
		end else begin
			capture_request_o <= 1'b1;
		end
		repeat (2) @(posedge rb_clk_o); // Held over two shift cycles
		capture_request_o <= 1'b0;
		tap_readback_o <= 1'b0;
		n = 0;
		while (capture_active_i !== 1'b1 && n < 40) begin
			@(negedge rb_clk_o);
			n++;
		end
		// Keep clocking until the active flag drops
		while (capture_active_i === 1'b1 && n < 400) begin
			@(negedge rb_clk_o);
			q.push_back(rb_data_i);
			n++;
			if (poke && q.size() == 10) begin
				@(posedge rb_clk_o);
				capture_request_o <= 1'b1;
			end
		end
		spin(1);
		capture_request_o <= 1'b0;
		spin(4);
		for (int i = 0; i < LEN; i++) begin
			s[LEN-1-i] = (q.size() >= LEN) ? q[q.size()-LEN+i] : 1'bx;
		end
	endtask : read
endmodule : readback_host

// ===== tb/tb_config_state_readback.sv
`timescale 1ns/10ps
module tb_config_state_readback
	import readback_pkg::*;
;
	localparam int NF  = 2;
	localparam int FB  = 16;
	localparam int LEN = (NF + 1) * (FB + 5) + 11;
	logic          clk, rb_clk, req, tap, active, rb_data, cfg_ready, done, status;
	logic          rst = 1'b1;
	logic [FB+3:0] cfg_word = 20'h00000;
	logic          cfg_valid = 1'b0;
	logic          ram_we = 1'b0;
	logic [0:0]    ram_frame = 1'h0;
	logic [3:0]    ram_bit = 4'h0;
	logic          ram_wdata = 1'b0;
	logic [1:0]    fg_x = 2'h1, fg_y = 2'h2, ff_a = 2'h3, ff_b = 2'h0; // Live cell nodes
	logic [1:0]    io_ff = 2'h2, in_a = 2'h1, in_b = 2'h3;             // Live io nodes
	logic          cap_en = 1'b0;
	logic [FB-1:0] mem [NF] = '{16'hA5C3, 16'h0F71}; // Expected configuration memory
	logic [LEN-1:0] got;
	int            n_fail = 0, total_checks = 0;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	config_state_readback #(.NUM_FRAMES(NF), .FRAME_BITS(FB), .NUM_CELLS(2), .NUM_IO(2),
		.FIFO_DEPTH(16)) i_config_state_readback (.clk_i(clk), .rst_i(rst), .rb_clk_i(rb_clk),
		.cfg_word_i(cfg_word), .cfg_valid_i(cfg_valid), .cfg_ready_o(cfg_ready),
		.config_done_o(done), .config_status_o(status), .ram_we_i(ram_we),
		.ram_frame_i(ram_frame), .ram_bit_i(ram_bit), .ram_wdata_i(ram_wdata),
		.cell_fg_x_i(fg_x), .cell_fg_y_i(fg_y), .cell_ff_out_a_i(ff_a), .cell_ff_out_b_i(ff_b),
		.io_out_ff_i(io_ff), .io_in_path_a_i(in_a), .io_in_path_b_i(in_b),
		.user_capture_en_i(cap_en), .capture_request_i(req), .tap_readback_i(tap),
		.capture_active_o(active), .rb_data_o(rb_data));
	readback_host #(.LEN(LEN)) i_readback_host (.rb_clk_o(rb_clk), .capture_request_o(req),
		.tap_readback_o(tap), .capture_active_i(active), .rb_data_i(rb_data));

	// Frame word with its four check bits
	function automatic logic [FB+3:0] frame_word(input logic [FB-1:0] d);
		logic [3:0] e;
		e = 4'h0;
		for (int i = 0; i < FB; i++) e[i%4] ^= d[i];
		return {d, e};
	endfunction : frame_word

	// Whole readback stream: framed memory, inverted live frame, then signature
	function automatic logic [LEN-1:0] expect_stream(input logic opt);
		logic [LEN-1:0] s;
		logic [FB-1:0]  d;
		logic [15:0]    sig;
		logic           fb;
		int             p;
		p = LEN;
		sig = 16'h0000;
		for (int f = 0; f <= NF; f++) begin
			d = (f < NF) ? mem[f] : {FB{1'b1}};
			for (int c = 0; c < 2 && f == NF && opt; c++) begin
				d[4*c+3 -: 4] = ~{fg_x[c], fg_y[c], ff_a[c], ff_b[c]};
				d[8+3*c+2 -: 3] = ~{io_ff[c], in_a[c], in_b[c]};
			end
			p = p - 1;
			s[p] = 1'b0;
			for (int i = FB - 1; i >= 0; i--) begin
				p = p - 1;
				s[p] = d[i];
			end
			repeat (4) begin
				p = p - 1;
				s[p] = 1'b1;
			end
		end
		for (int i = LEN - 1; i >= 11; i--) begin
			fb = sig[15] ^ s[i];
			sig = {sig[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
		end
		s[10:0] = sig[10:0];
		return s;
	endfunction : expect_stream

	task automatic cmp_bit(input string what, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %b seen %b", what, e, g);
		end
	endtask : cmp_bit

	task automatic cmp_vec(input string what, input logic [LEN-1:0] e, input logic [LEN-1:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_vec

	// Offer every frame back to back, optionally spoiling one check bit of frame 0
	task automatic load_frames(input logic bad);
		for (int f = 0; f < NF; f++) begin
			@(posedge clk);
			cfg_word <= frame_word(mem[f]) ^ ((bad && f == 0) ? 20'h00001 : 20'h00000);
			cfg_valid <= 1'b1;
		end
		@(posedge clk);
		cfg_valid <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : load_frames

	task automatic t_load();
		int n;
		load_frames(1'b0);
		cmp_bit("config done", 1'b1, done);
		cmp_bit("config status", 1'b1, status);
		// Loading is over, so extra words pile up until the buffer refuses
		@(posedge clk);
		cfg_valid <= 1'b1;
		n = 0;
		while (n < 40) begin
			@(negedge clk);
			if (cfg_ready !== 1'b1) break;
			n++;
		end
		@(posedge clk);
		cfg_valid <= 1'b0;
		cmp_bit("fifo full at 17", 1'b1, n == 17);
		cmp_bit("done after fill", 1'b1, done);
	endtask : t_load

	task automatic do_read(input logic opt, input bit use_tap, input bit poke);
		@(posedge clk);
		cap_en <= opt;
		repeat (3) @(posedge clk);
		i_readback_host.read(use_tap, poke, got);
	endtask : do_read

	task automatic t_plain();
		do_read(1'b0, 1'b0, 1'b0);
		cmp_vec("stream no live", expect_stream(1'b0), got);
	endtask : t_plain

	task automatic t_live();
		do_read(1'b1, 1'b1, 1'b1);
		cmp_vec("stream live", expect_stream(1'b1), got);
		cmp_bit("no restart", 1'b0, active);
		cmp_bit("done kept", 1'b1, done);
	endtask : t_live

	task automatic t_ram();
		@(posedge clk);
		ram_we <= 1'b1;
		ram_frame <= 1'h1;
		ram_bit <= 4'h5;
		ram_wdata <= ~mem[1][5];
		mem[1][5] = ~mem[1][5];
		@(posedge clk);
		ram_we <= 1'b0;
		do_read(1'b0, 1'b0, 1'b0);
		cmp_vec("stream after ram write", expect_stream(1'b0), got);
	endtask : t_ram

	task automatic t_bad();
		@(posedge clk);
		rst <= 1'b1;
		// The system clock branch ends last, so reset is released on a system clock edge
		fork
			i_readback_host.spin(4);
			repeat (5) @(posedge clk);
		join
		rst <= 1'b0;
		load_frames(1'b1);
		cmp_bit("status after bad frame", 1'b0, status);
		cmp_bit("done after bad frame", 1'b0, done);
	endtask : t_bad

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	// Reset with the shift clock running, then the scenarios in turn
	initial begin
		fork
			i_readback_host.spin(9);
			repeat (12) @(posedge clk);
		join
		rst <= 1'b0;
		t_load();
		t_plain();
		t_live();
		t_ram();
		t_bad();
		tally_and_finish();
	end

	// Hang guard, over ten times the expected run length
	initial begin
		#500000;
		n_fail++;
		$display("BAD watchdog expected end seen hang");
		tally_and_finish();
	end
endmodule : tb_config_state_readback
